//--- rtl/vbo_pkg.sv
// Constants and types for the vector register array block.
// Assumes one core clock and a single issuing pipeline stage.
package vbo_pkg;

    // ********************************************************
    // Geometry
    // ********************************************************
    localparam int NUM_REGS   = 32;
    localparam int REG_IDX_W  = 5;
    localparam int VEC_BITS   = 128;
    localparam int BYTE_BITS  = 8;
    localparam int HALF_BITS  = 16;
    localparam int WORD_BITS  = 32;
    localparam int NUM_BYTES  = VEC_BITS / BYTE_BITS;
    localparam int NUM_WORDS  = VEC_BITS / WORD_BITS;
    localparam int ADDR_W     = 32;
    localparam int ALIGN_BITS = 4;

    // ********************************************************
    // Reset values and floating-point encodings
    // ********************************************************
    localparam logic [VEC_BITS-1:0]   VEC_RESET  = 128'h0;
    localparam logic [ADDR_W-1:0]     ADDR_RESET = 32'h0;
    localparam logic [REG_IDX_W-1:0]  IDX_RESET  = 5'h0;
    localparam logic [ALIGN_BITS-1:0] ALIGN_ZERO = 4'h0;
    localparam logic [WORD_BITS-1:0]  FP_QNAN    = 32'h7fc00000;
    localparam logic [7:0]            FP_EXP_MAX = 8'hff;
    localparam logic [7:0]            FP_EXP_MIN = 8'h00;
    localparam logic [22:0]           FP_MANT_0  = 23'h0;

    // ********************************************************
    // Operations and element sizes
    // ********************************************************
    typedef enum logic [2:0] {
        OP_MOVE, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_SEL, OP_FMAX
    } vbo_op_e;

    typedef enum logic [1:0] {
        SZ_BYTE, SZ_HALF, SZ_WORD
    } vbo_size_e;

endpackage : vbo_pkg

//--- rtl/vbo_vector_reg_file.sv
// Vector register array with SIMD ALU, load/store byte mapping, FP modes.
// Assumes the issuing logic sends aligned addresses and one op per port.
`timescale 1ns/100ps

// Operation
// - 32 separate registers of 128 bits
// - One to three sources, one destination
// - Same operation on every element together
// - Memory moves only via load and store
// - Byte element 0 most significant, 15 least
// - Load puts address byte into element 0
// - Store writes element 0 to address
// - Compliant or faster non-compliant FP mode
// - Compliant mode follows strict layered FP defaults
// - Elements of bytes, halfwords or words
module vbo_vector_reg_file
    import vbo_pkg::*;
(
    // Clock and reset
    input  wire logic                 I_CLOCK,
    input  wire logic                 I_RESETN,
    // Arithmetic issue
    input  wire logic                 I_OP_VALID,
    input  wire vbo_op_e              I_OP_CODE,
    input  wire vbo_size_e            I_OP_SIZE,
    input  wire logic                 I_FP_COMPLIANT,
    input  wire logic [REG_IDX_W-1:0] I_OP_SRC_A,
    input  wire logic [REG_IDX_W-1:0] I_OP_SRC_B,
    input  wire logic [REG_IDX_W-1:0] I_OP_SRC_C,
    input  wire logic [REG_IDX_W-1:0] I_OP_DST,
    // Load from memory, byte at lowest address in bits 7:0
    input  wire logic                 I_LD_VALID,
    input  wire logic [REG_IDX_W-1:0] I_LD_DST,
    input  wire logic [VEC_BITS-1:0]  I_LD_DATA,
    // Store request
    input  wire logic                 I_ST_VALID,
    input  wire logic [REG_IDX_W-1:0] I_ST_SRC,
    input  wire logic [ADDR_W-1:0]    I_ST_ADDR,
    // Arithmetic result
    output logic                      O_ALU_VALID,
    output logic [REG_IDX_W-1:0]      O_ALU_DST,
    output logic [VEC_BITS-1:0]       O_ALU_RESULT,
    // Store to memory, byte at lowest address in bits 7:0
    output logic                      O_ST_VALID,
    output logic [ADDR_W-1:0]         O_ST_ADDR,
    output logic [VEC_BITS-1:0]       O_ST_DATA
);

    // ********************************************************
    // Element functions
    // ********************************************************
    // Carry chain broken at lane edges so one adder serves all sizes
    function automatic logic [WORD_BITS-1:0] lane_addsub(
        input logic [WORD_BITS-1:0] a,
        input logic [WORD_BITS-1:0] b,
        input vbo_size_e            sz,
        input logic                 sub
    );
        logic [WORD_BITS-1:0] bb;
        logic [WORD_BITS-1:0] r;
        logic                 c;
        int                   k;
        bb = sub ? ~b : b;
        r  = '0;
        c  = sub;
        for (k = 0; k < WORD_BITS; k++) begin
            r[k] = a[k] ^ bb[k] ^ c;
            c    = (a[k] & bb[k]) | (a[k] & c) | (bb[k] & c);
            if ((sz == SZ_BYTE && (k % BYTE_BITS) == BYTE_BITS - 1) ||
                (sz == SZ_HALF && (k % HALF_BITS) == HALF_BITS - 1)) begin
                c = sub;
            end
        end
        return r;
    endfunction : lane_addsub

    // Ordering key: negative zero sorts below positive zero
    function automatic logic [WORD_BITS-1:0] fp_key(
        input logic [WORD_BITS-1:0] x
    );
        return x[31] ? ~x : {1'b1, x[30:0]};
    endfunction : fp_key

    function automatic logic [WORD_BITS-1:0] fp_max(
        input logic [WORD_BITS-1:0] a,
        input logic [WORD_BITS-1:0] b,
        input logic                 strict
    );
        logic [WORD_BITS-1:0] fa;
        logic [WORD_BITS-1:0] fb;
        logic                 nan_a;
        logic                 nan_b;
        nan_a = (a[30:23] == FP_EXP_MAX) && (a[22:0] != FP_MANT_0);
        nan_b = (b[30:23] == FP_EXP_MAX) && (b[22:0] != FP_MANT_0);
        fa    = a;
        fb    = b;
        // Fast mode skips NaN care and flushes denormals to signed zero
        if (!strict && a[30:23] == FP_EXP_MIN) begin
            fa = {a[31], 31'h0};
        end
        if (!strict && b[30:23] == FP_EXP_MIN) begin
            fb = {b[31], 31'h0};
        end
        if (strict && (nan_a || nan_b)) begin
            return FP_QNAN;
        end
        return (fp_key(fa) >= fp_key(fb)) ? fa : fb;
    endfunction : fp_max

    // ********************************************************
    // Register array and operand reads
    // ********************************************************
    logic [VEC_BITS-1:0] vreg [0:NUM_REGS-1];
    logic [VEC_BITS-1:0] src_a;
    logic [VEC_BITS-1:0] src_b;
    logic [VEC_BITS-1:0] src_c;
    logic [VEC_BITS-1:0] next_result;
    logic [VEC_BITS-1:0] ld_map;
    logic [VEC_BITS-1:0] st_map;

    assign src_a = vreg[I_OP_SRC_A];
    assign src_b = vreg[I_OP_SRC_B];
    assign src_c = vreg[I_OP_SRC_C];

    // ********************************************************
    // Lanewise datapath and byte mapping
    // ********************************************************
    genvar gw;
    generate
        for (gw = 0; gw < NUM_WORDS; gw++) begin : g_word
            logic [WORD_BITS-1:0] a;
            logic [WORD_BITS-1:0] b;
            logic [WORD_BITS-1:0] c;
            logic [WORD_BITS-1:0] r;
            assign a = src_a[gw*WORD_BITS +: WORD_BITS];
            assign b = src_b[gw*WORD_BITS +: WORD_BITS];
            assign c = src_c[gw*WORD_BITS +: WORD_BITS];
            always_comb begin
                case (I_OP_CODE)
                    OP_MOVE: r = a;
                    OP_ADD:  r = lane_addsub(a, b, I_OP_SIZE, 1'b0);
                    OP_SUB:  r = lane_addsub(a, b, I_OP_SIZE, 1'b1);
                    OP_AND:  r = a & b;
                    OP_OR:   r = a | b;
                    OP_XOR:  r = a ^ b;
                    OP_SEL:  r = (a & ~c) | (b & c);
                    OP_FMAX: r = fp_max(a, b, I_FP_COMPLIANT);
                    default: r = a;
                endcase
            end
            assign next_result[gw*WORD_BITS +: WORD_BITS] = r;
        end
        // Element 0 sits at the top of the vector: byte 0 is the MSB
        for (gw = 0; gw < NUM_BYTES; gw++) begin : g_byte
            assign ld_map[VEC_BITS-1-gw*BYTE_BITS -: BYTE_BITS] =
                I_LD_DATA[gw*BYTE_BITS +: BYTE_BITS];
            assign st_map[gw*BYTE_BITS +: BYTE_BITS] =
                vreg[I_ST_SRC][VEC_BITS-1-gw*BYTE_BITS -: BYTE_BITS];
        end
    endgenerate

    // ********************************************************
    // Array writes
    // ********************************************************
    // No reset: contents are undefined until written.
    // Load is applied last, so it wins a same-register clash.
    always_ff @(posedge I_CLOCK) begin
        if (I_OP_VALID) begin
            vreg[I_OP_DST] <= next_result;
        end
        if (I_LD_VALID) begin
            vreg[I_LD_DST] <= ld_map;
        end
    end

    // ********************************************************
    // Result and store outputs
    // ********************************************************
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_ALU_VALID  <= 1'b0;
            O_ALU_DST    <= IDX_RESET;
            O_ALU_RESULT <= VEC_RESET;
        end else begin
            O_ALU_VALID <= I_OP_VALID;
            if (I_OP_VALID) begin
                O_ALU_DST    <= I_OP_DST;
                O_ALU_RESULT <= next_result;
            end
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_ST_VALID <= 1'b0;
            O_ST_ADDR  <= ADDR_RESET;
            O_ST_DATA  <= VEC_RESET;
        end else begin
            O_ST_VALID <= I_ST_VALID;
            if (I_ST_VALID) begin
                // Low bits dropped rather than trapped
                O_ST_ADDR <= {I_ST_ADDR[ADDR_W-1:ALIGN_BITS],
                              ALIGN_ZERO};
                O_ST_DATA <= st_map;
            end
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    logic [REG_IDX_W-1:0] ld_dst_q;
    logic [VEC_BITS-1:0]  ld_chk;
    logic [7:0]           add_b15;
    logic [31:0]          add_w3;
    logic [7:0]           st_b0;
    logic [7:0]           st_b15;
    logic                 a_nan;
    logic                 a_den;

    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ld_dst_q <= IDX_RESET;
        end else begin
            ld_dst_q <= I_LD_DST;
        end
    end

    assign ld_chk  = vreg[ld_dst_q];
    assign add_b15 = src_a[7:0] + src_b[7:0];
    assign add_w3  = src_a[31:0] + src_b[31:0];
    assign st_b0   = vreg[I_ST_SRC][127:120];
    assign st_b15  = vreg[I_ST_SRC][7:0];
    assign a_nan   = (src_a[30:23] == FP_EXP_MAX) && (src_a[22:0] != '0);
    assign a_den   = (src_a[30:23] == FP_EXP_MIN);

    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESETN);

    a_one_dest: assert property (
        I_OP_VALID |=> O_ALU_VALID && O_ALU_DST == $past(I_OP_DST))
        else $error("result missing or wrong destination");
    a_no_stray: assert property (
        O_ALU_VALID |-> $past(I_OP_VALID))
        else $error("result without an issued op");
    a_byte_lane: assert property (
        I_OP_VALID && I_OP_CODE == OP_ADD && I_OP_SIZE == SZ_BYTE
        |=> O_ALU_RESULT[7:0] == $past(add_b15))
        else $error("byte lane add wrong");
    a_word_lane: assert property (
        I_OP_VALID && I_OP_CODE == OP_ADD && I_OP_SIZE == SZ_WORD
        |=> O_ALU_RESULT[31:0] == $past(add_w3))
        else $error("word lane add wrong");
    a_store_first: assert property (
        I_ST_VALID |=> O_ST_VALID && O_ST_DATA[7:0] == $past(st_b0))
        else $error("store byte 0 misplaced");
    a_store_last: assert property (
        I_ST_VALID |=> O_ST_DATA[127:120] == $past(st_b15))
        else $error("store byte 15 misplaced");
    a_load_first: assert property (
        I_LD_VALID |=> ld_chk[127:120] == $past(I_LD_DATA[7:0]))
        else $error("load byte 0 misplaced");
    a_load_last: assert property (
        I_LD_VALID |=> ld_chk[7:0] == $past(I_LD_DATA[127:120]))
        else $error("load byte 15 misplaced");
    a_fp_nan: assert property (
        I_OP_VALID && I_OP_CODE == OP_FMAX && I_FP_COMPLIANT && a_nan
        |=> O_ALU_RESULT[31:0] == FP_QNAN)
        else $error("compliant max lost NaN");
    a_fp_flush: assert property (
        I_OP_VALID && I_OP_CODE == OP_FMAX && !I_FP_COMPLIANT && a_den
        && src_b[31:0] == 32'h0 |=> O_ALU_RESULT[31:0] == 32'h0)
        else $error("fast max did not flush");
    a_st_align: assert property (
        O_ST_VALID |-> O_ST_ADDR[ALIGN_BITS-1:0] == ALIGN_ZERO)
        else $error("store address not aligned");

    c_load: cover property (I_LD_VALID ##2 I_ST_VALID);
    c_sel:  cover property (I_OP_VALID && I_OP_CODE == OP_SEL);
    c_nan:  cover property (I_OP_VALID && I_OP_CODE == OP_FMAX && a_nan);

endmodule : vbo_vector_reg_file

//--- sim/vbo_mem_model.sv
// Memory side model: byte array feeding loads, absorbing stores.
// Assumes the bench picks the quadword by a byte address it drives.
`timescale 1ns/100ps
module vbo_mem_model
    import vbo_pkg::*;
(
    // Clock
    input  wire logic                I_CLOCK,
    // Load side
    input  wire logic                i_ld_valid,
    input  wire logic [5:0]          i_ld_addr,
    output logic      [VEC_BITS-1:0] o_ld_data,
    // Store side
    input  wire logic                i_st_valid,
    input  wire logic [ADDR_W-1:0]   i_st_addr,
    input  wire logic [VEC_BITS-1:0] i_st_data
);
    logic [7:0] mem [0:63];
    // Aligned fetch only; idle bus shows inverted data, not a held value
    always_comb begin
        for (int k = 0; k < NUM_BYTES; k++) begin
            o_ld_data[8*k +: 8] = i_ld_valid ?
                mem[6'({i_ld_addr[5:4], 4'h0} + k)] :
                ~mem[6'({i_ld_addr[5:4], 4'h0} + k)];
        end
    end
    // Plain process: the bench preloads this array directly
    always @(posedge I_CLOCK) begin
        if (i_st_valid) begin
            for (int k = 0; k < NUM_BYTES; k++) begin
                mem[6'(i_st_addr[5:0] + k)] <= i_st_data[8*k +: 8];
            end
        end
    end
endmodule : vbo_mem_model

//--- sim/vbo_vector_reg_file_tb_top.sv
// Bench for the vector register array, scenario tasks in sequence.
// Assumes the memory model above and the design package.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
    failures++; $display("ERROR %s exp %h got %h", n, e, g); end end
module vbo_vector_reg_file_tb_top
    import vbo_pkg::*;
;
    logic I_CLOCK = 1'b0, I_RESETN = 1'b0, op_v = 1'b0, fp = 1'b0;
    logic ld_v = 1'b0, st_v = 1'b0, alu_v, o_st_v;
    vbo_op_e   code = OP_MOVE;
    vbo_size_e size = SZ_BYTE;
    logic [4:0]  sa = 5'h0, sb = 5'h0, sc = 5'h0, dst = 5'h0;
    logic [4:0]  ld_dst = 5'h0, st_src = 5'h0, alu_dst;
    logic [5:0]  ld_addr = 6'h0;
    logic [31:0] st_addr = 32'h0, o_st_addr;
    logic [127:0] ld_data, res, o_st_data, v1;
    int failures = 0, checked = 0;
    localparam logic [127:0] ONES = {16{8'hff}}, LOWS = {16{8'h01}};
    always #25 I_CLOCK = ~I_CLOCK;

    vbo_vector_reg_file dut (.I_CLOCK(I_CLOCK), .I_RESETN(I_RESETN),
        .I_OP_VALID(op_v), .I_OP_CODE(code), .I_OP_SIZE(size),
        .I_FP_COMPLIANT(fp), .I_OP_SRC_A(sa), .I_OP_SRC_B(sb),
        .I_OP_SRC_C(sc), .I_OP_DST(dst), .I_LD_VALID(ld_v),
        .I_LD_DST(ld_dst), .I_LD_DATA(ld_data), .I_ST_VALID(st_v),
        .I_ST_SRC(st_src), .I_ST_ADDR(st_addr), .O_ALU_VALID(alu_v),
        .O_ALU_DST(alu_dst), .O_ALU_RESULT(res), .O_ST_VALID(o_st_v),
        .O_ST_ADDR(o_st_addr), .O_ST_DATA(o_st_data));
    vbo_mem_model mdl (.I_CLOCK(I_CLOCK), .i_ld_valid(ld_v),
        .i_ld_addr(ld_addr), .o_ld_data(ld_data), .i_st_valid(o_st_v),
        .i_st_addr(o_st_addr), .i_st_data(o_st_data));

    // ********************************************************
    // Bus tasks
    // ********************************************************
    task automatic close_out();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out
    // Register view value placed so element k sits at address b+k
    task automatic put(input logic [5:0] b, input logic [127:0] v);
        for (int k = 0; k < 16; k++) mdl.mem[6'(b + k)] = v[127-8*k -: 8];
    endtask : put
    task automatic load(input logic [4:0] r, input logic [127:0] v);
        put(6'h0, v);
        @(negedge I_CLOCK) {ld_v, ld_dst, ld_addr} = {1'b1, r, 6'h0};
        @(negedge I_CLOCK) ld_v = 1'b0;
    endtask : load
    task automatic op(input vbo_op_e c, input vbo_size_e z,
        input logic [4:0] a, b, s, d, input logic f);
        @(negedge I_CLOCK) begin
            op_v = 1'b1;
            code = c;
            size = z;
            {sa, sb, sc, dst, fp} = {a, b, s, d, f};
        end
        @(negedge I_CLOCK) op_v = 1'b0;
        `CHK("alu_valid", 1'b1, alu_v)
        `CHK("alu_dst", d, alu_dst)
    endtask : op
    task automatic store(input logic [4:0] r, input logic [31:0] a);
        int n;
        n = 0;
        @(negedge I_CLOCK) {st_v, st_src, st_addr} = {1'b1, r, a};
        @(negedge I_CLOCK) st_v = 1'b0;
        while (o_st_v !== 1'b1) begin
            n++;
            if (n > 4) begin
                failures++;
                close_out();
            end
            @(negedge I_CLOCK);
        end
    endtask : store

    // ********************************************************
    // Scenarios
    // ********************************************************
    task automatic t_map();
        v1 = 128'h00112233_44556677_8899aabb_ccddeeff;
        load(5'h1, v1);
        store(5'h1, 32'h23);
        `CHK("st_addr", 32'h20, o_st_addr)
        `CHK("st_lane0", v1[127:120], o_st_data[7:0])
        @(negedge I_CLOCK);
        `CHK("mem32", v1[127:120], mdl.mem[32])
        `CHK("mem47", v1[7:0], mdl.mem[47])
        op(OP_MOVE, SZ_BYTE, 5'h1, 5'h0, 5'h0, 5'h2, 1'b0);
        `CHK("move", v1, res)
        `CHK("byte0", mdl.mem[0], res[127:120])
        `CHK("byte15", mdl.mem[15], res[7:0])
    endtask : t_map
    task automatic t_regs();
        load(5'h0, ~v1);
        load(5'h1f, v1);
        op(OP_MOVE, SZ_BYTE, 5'h1f, 5'h0, 5'h0, 5'h5, 1'b0);
        `CHK("reg31", v1, res)
        op(OP_MOVE, SZ_BYTE, 5'h0, 5'h0, 5'h0, 5'h6, 1'b0);
        `CHK("reg0", ~v1, res)
    endtask : t_regs
    task automatic t_lanes();
        load(5'h3, ONES);
        load(5'h4, LOWS);
        op(OP_ADD, SZ_BYTE, 5'h3, 5'h4, 5'h0, 5'h9, 1'b0);
        `CHK("add_b", 128'h0, res)
        op(OP_ADD, SZ_HALF, 5'h3, 5'h4, 5'h0, 5'h9, 1'b0);
        `CHK("add_h", {8{16'h0100}}, res)
        op(OP_ADD, SZ_WORD, 5'h3, 5'h4, 5'h0, 5'h9, 1'b0);
        `CHK("add_w", {4{32'h01010100}}, res)
        op(OP_SUB, SZ_BYTE, 5'h4, 5'h3, 5'h0, 5'h9, 1'b0);
        `CHK("sub_b", {16{8'h02}}, res)
        op(OP_XOR, SZ_BYTE, 5'h3, 5'h4, 5'h0, 5'h9, 1'b0);
        `CHK("xor", {16{8'hfe}}, res)
        op(OP_AND, SZ_BYTE, 5'h3, 5'h4, 5'h0, 5'h9, 1'b0);
        `CHK("and", LOWS, res)
        op(OP_OR, SZ_BYTE, 5'h9, 5'h4, 5'h0, 5'h9, 1'b0);
        `CHK("or", LOWS, res)
        op(OP_SEL, SZ_BYTE, 5'h3, 5'h4, 5'h1f, 5'ha, 1'b0);
        `CHK("sel", (v1 & LOWS) | (~v1 & ONES), res)
    endtask : t_lanes
    // NaN, signed zeros, normal values; fast mode checked on normals only
    task automatic t_fp();
        load(5'h7, {32'h7f800001, 32'h80000000, 32'h3f800000, 32'hc0000000});
        load(5'h8, {32'h3f800000, 32'h00000000, 32'h40000000, 32'hbf800000});
        op(OP_FMAX, SZ_WORD, 5'h7, 5'h8, 5'h0, 5'hb, 1'b1);
        `CHK("fmax_c", {FP_QNAN, 96'h0_40000000_bf800000}, res)
        op(OP_FMAX, SZ_WORD, 5'h7, 5'h8, 5'h0, 5'hb, 1'b0);
        `CHK("fmax_f", 64'h40000000_bf800000, res[63:0])
    endtask : t_fp
    // Denormals kept when compliant, flushed when fast; NaN in low word
    task automatic t_denorm();
        load(5'hc, {32'h7f800001, 32'h3f800000, 32'h80000001, 32'h00000001});
        load(5'hd, 128'h0);
        load(5'he, {96'h0, 32'h7f800001});
        op(OP_FMAX, SZ_WORD, 5'hc, 5'hd, 5'h0, 5'hb, 1'b1);
        `CHK("den_c", {FP_QNAN, 32'h3f800000, 64'h1}, res)
        op(OP_FMAX, SZ_WORD, 5'hc, 5'hd, 5'h0, 5'hb, 1'b0);
        `CHK("den_f", {32'h3f800000, 64'h0}, res[95:0])
        op(OP_FMAX, SZ_WORD, 5'he, 5'hd, 5'h0, 5'hb, 1'b1);
        `CHK("nan_lo", {96'h0, FP_QNAN}, res)
    endtask : t_denorm

    initial begin
        repeat (5) @(negedge I_CLOCK);
        I_RESETN = 1'b1;
        t_map();
        t_regs();
        t_lanes();
        t_fp();
        t_denorm();
        close_out();
    end
endmodule : vbo_vector_reg_file_tb_top
